// [common/nvck_params.svh]
// constants for the memory checksum and diagnostic status block
`ifndef NVCK_PARAMS_SVH
`define NVCK_PARAMS_SVH
`define NVCK_CLK_PERIOD_NS 25
`define NVCK_CMD_ENTRY_NS 20000000
`define NVCK_PUMP_SETTLE_NS 1000000
`define NVCK_CRC_INIT 8'hFF
`define NVCK_CRC_POLY 9'h107
`define NVCK_CRC_FIRST_ADDR 4'h8
`define NVCK_CRC_LAST_ADDR 4'hF
`define NVCK_REGION_NVM 3'h0
`define NVCK_CMD_CTRL_WR 8'h82
`define NVCK_CMD_CTRL_RD 8'h83
`define NVCK_CMD_SIG_WR 8'h94
`define NVCK_CMD_TEST_WR 8'h96
`define NVCK_CMD_TEST_RD 8'h97
`define NVCK_SIGNATURE 16'h16F4
`define NVCK_BIT_DIAG_PRESENT 15
`define NVCK_BIT_DIAG_OFF 14
`define NVCK_BIT_UNDERVOLT 12
`define NVCK_BIT_PUMP_CLK 11
`define NVCK_BIT_CORR 8
`define NVCK_BIT_DOUBLE 7
`define NVCK_BIT_FIELD_LOSS 6
`define NVCK_BIT_BOND 5
`define NVCK_BIT_CRC_BAD 4
`define NVCK_BIT_WRITE_EN 11
`endif

// [common/nvck_pkg.sv]
// types and checksum step shared by both ends
`default_nettype none
`include "nvck_params.svh"
package nvck_pkg;
  typedef logic [15:0] nvck_word_t;
  typedef enum logic [1:0] {CK_FETCH = 2'b00, CK_SHIFT = 2'b01, CK_DONE = 2'b11} nvck_ck_state_t;
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_XFER = 2'b01, M_SHIFT = 2'b11, M_WAIT = 2'b10}
    nvck_m_state_t;
  typedef enum logic [1:0] {OP_RAW = 2'h0, OP_ENTER = 2'h1, OP_ARM = 2'h2, OP_CRC = 2'h3}
    nvck_op_t;

  // one data bit into the checksum: shift in at the bottom, reduce when bit 8 rises
  function automatic logic [7:0] nvck_crc_bit(input logic [7:0] crc, input logic din);
    logic [8:0] t;
    t = {crc, din};
    if (t[8]) begin
      t = t ^ `NVCK_CRC_POLY;
    end
    return t[7:0];
  endfunction : nvck_crc_bit
endpackage : nvck_pkg
`default_nettype wire

// [common/nvck_link_if.sv]
// word-level programming link between master and device
`timescale 1ns/1ps
`default_nettype none
interface nvck_link_if;
  logic req;
  logic [7:0] cmd;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport dev (input req, input cmd, input wdata, output ack, output rdata);
  modport mst (output req, output cmd, output wdata, input ack, input rdata);
endinterface : nvck_link_if
`default_nettype wire

// [design/nvck_device.sv]
// device end: start-up memory checksum, control and diagnostic status register
`timescale 1ns/1ps
`default_nettype none
`include "nvck_params.svh"
module nvck_device #(
  parameter int unsigned CMD_ENTRY_CYC =
    (`NVCK_CMD_ENTRY_NS + `NVCK_CLK_PERIOD_NS - 1) / `NVCK_CLK_PERIOD_NS
) (
  input wire logic sys_clk,
  input wire logic rst,
  nvck_link_if.dev link,
  output logic [3:0] nvm_addr,
  input wire nvck_pkg::nvck_word_t nvm_rdata,
  input wire logic nvm_corr_err,
  input wire logic nvm_dbl_err,
  output logic nvm_wr,
  output nvck_pkg::nvck_word_t nvm_wdata,
  input wire logic undervoltage_pin,
  input wire logic field_loss_pin,
  input wire logic bond_fault_pin,
  input wire logic field_loss_detect_en,
  output logic cmd_mode,
  output logic diag_mode,
  output logic pump_on,
  output logic check_done
);
  import nvck_pkg::*;

  nvck_ck_state_t ck_state_r;
  logic [3:0] ck_addr_r;
  nvck_word_t ck_word_r;
  logic [3:0] ck_bit_r;
  logic [7:0] crc_r;
  logic [7:0] stored_r;
  logic crc_bad_r;
  logic [31:0] entry_cnt_r;
  logic cmd_mode_r;
  logic diag_override_off_r;
  logic pump_clock_enable_r;
  logic write_enable_r;
  logic undervoltage_flag_r;
  logic corr_flag_r;
  logic double_bit_fault_flag_r;
  logic field_loss_flag_r;
  logic bond_fault_flag_r;
  logic ack_r;
  nvck_word_t rdata_r;
  logic nvm_wr_r;
  nvck_word_t nvm_wdata_r;
  logic [2:0] pin_sync1_r;
  logic [2:0] pin_sync2_r;

  // raw pins are asynchronous to sys_clk; two stages before any use
  wire [2:0] pins_raw = {undervoltage_pin, field_loss_pin, bond_fault_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pin_sync1_r[gi] <= 1'b0;
          pin_sync2_r[gi] <= 1'b0;
        end else begin
          pin_sync1_r[gi] <= pins_raw[gi];
          pin_sync2_r[gi] <= pin_sync1_r[gi];
        end
      end
    end
  endgenerate
  wire uv_s = pin_sync2_r[2];
  wire loss_s = pin_sync2_r[1];
  wire bond_s = pin_sync2_r[0];

  // start-up checksum engine
  wire ck_done = (ck_state_r == CK_DONE);
  wire ck_is_last = (ck_addr_r == `NVCK_CRC_LAST_ADDR);
  wire [7:0] crc_nxt = nvck_crc_bit(crc_r, ck_word_r[ck_bit_r]);
  wire ck_fetch = (ck_state_r == CK_FETCH);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ck_state_r <= CK_FETCH;
      ck_addr_r <= `NVCK_CRC_FIRST_ADDR;
      ck_word_r <= 16'h0000;
      ck_bit_r <= 4'hF;
      crc_r <= `NVCK_CRC_INIT;
      stored_r <= 8'h00;
      crc_bad_r <= 1'b0;
    end else begin
      unique case (ck_state_r)
        CK_FETCH: begin
          ck_word_r <= ck_is_last ? {nvm_rdata[15:8], 8'h00} : nvm_rdata;
          if (ck_is_last) begin
            stored_r <= nvm_rdata[7:0];
          end
          ck_bit_r <= 4'hF;
          ck_state_r <= CK_SHIFT;
        end
        CK_SHIFT: begin
          crc_r <= crc_nxt;
          ck_bit_r <= ck_bit_r - 4'h1;
          if (ck_bit_r == 4'h0) begin
            if (ck_is_last) begin
              crc_bad_r <= (crc_nxt != stored_r);
              ck_state_r <= CK_DONE;
            end else begin
              ck_addr_r <= ck_addr_r + 4'h1;
              ck_state_r <= CK_FETCH;
            end
          end
        end
        CK_DONE: begin
          ck_state_r <= CK_DONE;
        end
        default: begin
          ck_state_r <= CK_FETCH;
        end
      endcase
    end
  end

  // link decode; requests wait until the start-up check has finished
  wire take = link.req & ~ack_r & ck_done;
  wire is_nvm = (link.cmd[7:5] == `NVCK_REGION_NVM);
  wire is_read = link.cmd[0];
  wire [3:0] link_addr = link.cmd[4:1];
  wire diag_present = undervoltage_flag_r | corr_flag_r | double_bit_fault_flag_r
    | (field_loss_flag_r & field_loss_detect_en) | bond_fault_flag_r | crc_bad_r;
  wire window_open = (entry_cnt_r != 32'h0);
  // signature also accepted later while a diagnostic condition holds
  wire sig_hit = take & (link.cmd == `NVCK_CMD_SIG_WR) & (link.wdata == `NVCK_SIGNATURE)
    & (window_open | diag_present);
  wire acc = take & cmd_mode_r;
  wire ctrl_wr = acc & (link.cmd == `NVCK_CMD_CTRL_WR);
  wire test_wr = acc & (link.cmd == `NVCK_CMD_TEST_WR);
  wire nvm_rd = acc & is_nvm & is_read;
  // customer words only, and only with the pump armed
  wire nvm_wr_ok = acc & is_nvm & ~is_read & write_enable_r & pump_clock_enable_r
    & (link_addr >= `NVCK_CRC_FIRST_ADDR);
  wire readout = ck_fetch | nvm_rd;
  assign nvm_addr = ck_done ? link_addr : ck_addr_r;

  nvck_word_t ctrl_val;
  always_comb begin
    ctrl_val = 16'h0000;
    ctrl_val[`NVCK_BIT_DIAG_PRESENT] = diag_present;
    ctrl_val[`NVCK_BIT_UNDERVOLT] = undervoltage_flag_r;
    ctrl_val[`NVCK_BIT_PUMP_CLK] = pump_clock_enable_r;
    ctrl_val[`NVCK_BIT_CORR] = corr_flag_r;
    ctrl_val[`NVCK_BIT_DOUBLE] = double_bit_fault_flag_r;
    ctrl_val[`NVCK_BIT_FIELD_LOSS] = field_loss_flag_r;
    ctrl_val[`NVCK_BIT_BOND] = bond_fault_flag_r;
    ctrl_val[`NVCK_BIT_CRC_BAD] = crc_bad_r;
  end
  // bit 14 is write-only and reads back as zero
  wire [15:0] test_val = {4'h0, write_enable_r, 11'h000};
  wire [15:0] rd_val = ~cmd_mode_r ? 16'h0000
    : (link.cmd == `NVCK_CMD_CTRL_RD) ? ctrl_val
    : (link.cmd == `NVCK_CMD_TEST_RD) ? test_val
    : (is_nvm & is_read) ? nvm_rdata : 16'h0000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      entry_cnt_r <= 32'(CMD_ENTRY_CYC);
      cmd_mode_r <= 1'b0;
    end else begin
      if (window_open) begin
        entry_cnt_r <= entry_cnt_r - 32'h1;
      end
      // only a power-on reset leaves command mode
      if (sig_hit) begin
        cmd_mode_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      diag_override_off_r <= 1'b0;
      pump_clock_enable_r <= 1'b0;
      write_enable_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        diag_override_off_r <= link.wdata[`NVCK_BIT_DIAG_OFF];
        pump_clock_enable_r <= link.wdata[`NVCK_BIT_PUMP_CLK] & write_enable_r;
      end
      if (test_wr) begin
        write_enable_r <= link.wdata[`NVCK_BIT_WRITE_EN];
      end
    end
  end

  // flags hold until a power-on reset; a live condition sets them again
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      undervoltage_flag_r <= 1'b0;
      corr_flag_r <= 1'b0;
      double_bit_fault_flag_r <= 1'b0;
      field_loss_flag_r <= 1'b0;
      bond_fault_flag_r <= 1'b0;
    end else begin
      undervoltage_flag_r <= undervoltage_flag_r | uv_s;
      corr_flag_r <= corr_flag_r | (readout & nvm_corr_err);
      double_bit_fault_flag_r <= double_bit_fault_flag_r | (readout & nvm_dbl_err);
      field_loss_flag_r <= field_loss_flag_r | loss_s;
      bond_fault_flag_r <= bond_fault_flag_r | bond_s;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
      nvm_wr_r <= 1'b0;
      nvm_wdata_r <= 16'h0000;
    end else begin
      ack_r <= take;
      if (take) begin
        rdata_r <= rd_val;
      end
      nvm_wr_r <= nvm_wr_ok;
      if (nvm_wr_ok) begin
        nvm_wdata_r <= link.wdata;
      end
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rdata_r;
  assign nvm_wr = nvm_wr_r;
  assign nvm_wdata = nvm_wdata_r;
  assign cmd_mode = cmd_mode_r;
  assign diag_mode = diag_present & ~diag_override_off_r;
  assign pump_on = pump_clock_enable_r & write_enable_r;
  assign check_done = ck_done;
endmodule : nvck_device
`default_nettype wire

// [design/nvck_master.sv]
// programming master end: raw access, command entry, pump arming, checksum
`timescale 1ns/1ps
`default_nettype none
`include "nvck_params.svh"
module nvck_master #(
  parameter int unsigned PUMP_SETTLE_CYC =
    (`NVCK_PUMP_SETTLE_NS + `NVCK_CLK_PERIOD_NS - 1) / `NVCK_CLK_PERIOD_NS
) (
  input wire logic sys_clk,
  input wire logic rst,
  nvck_link_if.mst link,
  input wire logic start,
  input wire nvck_pkg::nvck_op_t op,
  input wire logic [7:0] cmd,
  input wire nvck_pkg::nvck_word_t wdata,
  output logic busy,
  output logic done,
  output nvck_pkg::nvck_word_t rdata,
  output logic [7:0] crc_value,
  output logic crc_match
);
  import nvck_pkg::*;

  nvck_m_state_t state_r;
  nvck_op_t op_r;
  logic [2:0] step_r;
  logic req_r;
  logic [7:0] cmd_r;
  nvck_word_t wdata_r;
  nvck_word_t rdata_r;
  nvck_word_t word_r;
  logic [3:0] bit_r;
  logic [7:0] crc_r;
  logic [7:0] stored_r;
  logic match_r;
  logic [31:0] wait_r;
  logic done_r;

  wire idle = (state_r == M_IDLE);
  wire [3:0] cur_addr = 4'(`NVCK_CRC_FIRST_ADDR + {1'b0, step_r});
  wire [3:0] next_addr = 4'(cur_addr + 4'h1);
  wire is_last = (cur_addr == `NVCK_CRC_LAST_ADDR);
  wire [7:0] crc_nxt = nvck_crc_bit(crc_r, word_r[bit_r]);
  wire [7:0] first_cmd = (op == OP_ENTER) ? `NVCK_CMD_SIG_WR
    : (op == OP_ARM) ? `NVCK_CMD_TEST_WR
    : (op == OP_CRC) ? {`NVCK_REGION_NVM, `NVCK_CRC_FIRST_ADDR, 1'b1} : cmd;
  wire [15:0] first_data = (op == OP_ENTER) ? `NVCK_SIGNATURE
    : (op == OP_ARM) ? 16'h0800 : wdata;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= M_IDLE;
      op_r <= OP_RAW;
      step_r <= 3'h0;
      req_r <= 1'b0;
      cmd_r <= 8'h00;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      word_r <= 16'h0000;
      bit_r <= 4'hF;
      crc_r <= `NVCK_CRC_INIT;
      stored_r <= 8'h00;
      match_r <= 1'b0;
      wait_r <= 32'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        M_IDLE: begin
          if (start) begin
            op_r <= op;
            step_r <= 3'h0;
            req_r <= 1'b1;
            cmd_r <= first_cmd;
            wdata_r <= first_data;
            crc_r <= `NVCK_CRC_INIT;
            state_r <= M_XFER;
          end
        end
        M_XFER: begin
          if (link.ack) begin
            req_r <= 1'b0;
            rdata_r <= link.rdata;
            unique case (op_r)
              OP_RAW, OP_ENTER: begin
                done_r <= 1'b1;
                state_r <= M_IDLE;
              end
              OP_ARM: begin
                if (step_r == 3'h0) begin
                  // pump clock only after write enable is in place
                  step_r <= 3'h1;
                  req_r <= 1'b1;
                  cmd_r <= `NVCK_CMD_CTRL_WR;
                  wdata_r <= 16'h0800;
                end else begin
                  wait_r <= 32'(PUMP_SETTLE_CYC) - 32'h1;
                  state_r <= M_WAIT;
                end
              end
              OP_CRC: begin
                word_r <= is_last ? {link.rdata[15:8], 8'h00} : link.rdata;
                if (is_last) begin
                  stored_r <= link.rdata[7:0];
                end
                bit_r <= 4'hF;
                state_r <= M_SHIFT;
              end
            endcase
          end
        end
        M_SHIFT: begin
          crc_r <= crc_nxt;
          bit_r <= bit_r - 4'h1;
          if (bit_r == 4'h0) begin
            if (is_last) begin
              match_r <= (crc_nxt == stored_r);
              done_r <= 1'b1;
              state_r <= M_IDLE;
            end else begin
              step_r <= step_r + 3'h1;
              req_r <= 1'b1;
              cmd_r <= {`NVCK_REGION_NVM, next_addr, 1'b1};
              state_r <= M_XFER;
            end
          end
        end
        M_WAIT: begin
          if (wait_r == 32'h0) begin
            done_r <= 1'b1;
            state_r <= M_IDLE;
          end else begin
            wait_r <= wait_r - 32'h1;
          end
        end
      endcase
    end
  end

  assign link.req = req_r;
  assign link.cmd = cmd_r;
  assign link.wdata = wdata_r;
  assign busy = ~idle;
  assign done = done_r;
  assign rdata = rdata_r;
  assign crc_value = crc_r;
  assign crc_match = match_r;
endmodule : nvck_master
`default_nettype wire

// [verification/nvck_link_properties.sv]
// link protocol assertions between master and device
`timescale 1ns/1ps
`default_nettype none
`include "nvck_params.svh"
module nvck_link_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [7:0] cmd,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a second ack cycle would be taken as an answer to the next request
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack lasted more than one cycle");
  a_ack_has_req: assert property (ack |-> $past(req))
    else $error("ack without a pending request");
  a_req_held: assert property (req && !ack |=> req && $stable(cmd) && $stable(wdata))
    else $error("request changed before its ack");
  // start-up check of 136 cycles is the longest wait for an answer
  a_req_answered: assert property (req |-> ##[0:300] ack)
    else $error("request not answered in time");
  a_rdata_hold: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  a_status_quiet: assert property (ack && cmd == `NVCK_CMD_CTRL_RD |->
    (rdata & 16'h660F) == 16'h0000)
    else $error("status read shows write-only or reserved bits");
  a_test_quiet: assert property (ack && cmd == `NVCK_CMD_TEST_RD |->
    (rdata & 16'hF7FF) == 16'h0000)
    else $error("test control read shows reserved bits");
  a_region_empty: assert property (ack && cmd[0] && cmd[7:5] != 3'h0 && cmd[7:5] != 3'h4 |->
    rdata == 16'h0000)
    else $error("reserved region read returned data");
endmodule : nvck_link_properties
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench: master and device joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "nvck_params.svh"
module testbench;
  import nvck_pkg::*;
  localparam nvck_word_t WORDS [8] = '{16'h0000, 16'hFFC1, 16'h0400, 16'h0100,
    16'h1300, 16'h0000, 16'h0000, 16'h00AA};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic m_start = 1'b0;
  nvck_op_t m_op = OP_RAW;
  logic [7:0] m_cmd = 8'h00;
  nvck_word_t m_wdata = 16'h0000;
  logic m_busy, m_done, m_match, cmd_mode, diag_mode, pump_on, check_done, nvm_wr;
  nvck_word_t m_rdata, nvm_rdata, nvm_wdata;
  logic [7:0] m_crc;
  logic [3:0] nvm_addr, wr_addr;
  logic corr_err = 1'b0;
  logic dbl_err = 1'b0;
  logic [3:0] pins = 4'h0; // undervoltage, field loss, bond, field loss enable
  nvck_word_t mem [16];
  int fails = 0;
  int num_checks = 0;
  nvck_link_if link_bus ();
  always #12.5 sys_clk = ~sys_clk;
  assign nvm_rdata = mem[nvm_addr];
  // the write lands at the address seen when the request was taken
  always @(posedge sys_clk) begin
    if (link_bus.req && !link_bus.ack)
      wr_addr <= nvm_addr;
    if (nvm_wr)
      mem[wr_addr] <= nvm_wdata;
  end
  nvck_device #(.CMD_ENTRY_CYC(200)) nvck_device_i (.sys_clk(sys_clk), .rst(rst),
    .link(link_bus), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata), .nvm_corr_err(corr_err),
    .nvm_dbl_err(dbl_err), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata),
    .undervoltage_pin(pins[3]), .field_loss_pin(pins[2]), .bond_fault_pin(pins[1]),
    .field_loss_detect_en(pins[0]), .cmd_mode(cmd_mode), .diag_mode(diag_mode),
    .pump_on(pump_on), .check_done(check_done));
  nvck_master #(.PUMP_SETTLE_CYC(10)) nvck_master_i (.sys_clk(sys_clk), .rst(rst),
    .link(link_bus), .start(m_start), .op(m_op), .cmd(m_cmd), .wdata(m_wdata), .busy(m_busy),
    .done(m_done), .rdata(m_rdata), .crc_value(m_crc), .crc_match(m_match));
  nvck_link_properties nvck_link_properties_i (.sys_clk(sys_clk), .rst(rst),
    .req(link_bus.req), .cmd(link_bus.cmd), .wdata(link_bus.wdata), .ack(link_bus.ack),
    .rdata(link_bus.rdata));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask : chk

  task automatic tend(input string name);
    $display("test %s finished", name);
  endtask : tend

  task automatic run_op(input nvck_op_t o, input logic [7:0] c, input nvck_word_t d);
    int k;
    @(negedge sys_clk);
    m_op = o;
    m_cmd = c;
    m_wdata = d;
    m_start = 1'b1;
    @(negedge sys_clk);
    m_start = 1'b0;
    chk("busy", {15'h0, m_busy}, 16'h0001);
    for (k = 0; k < 2000 && m_done !== 1'b1; k++) @(negedge sys_clk);
    chk("done", {15'h0, m_done}, 16'h0001);
  endtask : run_op

  task automatic rd(input logic [7:0] c, input nvck_word_t exp, input string what);
    run_op(OP_RAW, c, 16'h0000);
    chk(what, m_rdata, exp);
  endtask : rd

  task automatic do_reset();
    int k;
    rst = 1'b1;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    for (k = 0; k < 400 && check_done !== 1'b1; k++) @(negedge sys_clk);
    chk("check done", {15'h0, check_done}, 16'h0001);
    chk("check length", {15'h0, k >= 128}, 16'h0001);
  endtask : do_reset

  // reference sum over words 8h..Fh, worked bit by bit
  function automatic logic [7:0] crc8();
    logic [7:0] c;
    logic [8:0] t;
    nvck_word_t w;
    c = `NVCK_CRC_INIT;
    for (int a = 8; a < 16; a++) begin
      w = (a == 15) ? {mem[15][15:8], 8'h00} : mem[a];
      for (int b = 15; b >= 0; b--) begin
        t = {c, w[b]};
        if (t[8])
          t = t ^ `NVCK_CRC_POLY;
        c = t[7:0];
      end
    end
    return c;
  endfunction : crc8

  initial begin
    #(25 * 40000);
    fails++;
    complete_run();
  end

  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    for (int i = 0; i < 8; i++) mem[8 + i] = WORDS[i];
    do_reset();
    rd(8'h83, 16'h0000, "locked status");
    run_op(OP_ENTER, 8'h00, 16'h0000);
    chk("cmd mode", {15'h0, cmd_mode}, 16'h0001);
    rd(8'h83, 16'h8010, "bad sum status");
    chk("diag mode", {15'h0, diag_mode}, 16'h0001);
    tend("bad checksum");
    mem[15] = 16'h00A9;
    do_reset();
    run_op(OP_ENTER, 8'h00, 16'h0000);
    rd(8'h83, 16'h0000, "clean status");
    rd(8'h23, 16'h0000, "reserved region");
    run_op(OP_CRC, 8'h00, 16'h0000);
    chk("crc", {8'h00, m_crc}, 16'h00A9);
    chk("crc match", {15'h0, m_match}, 16'h0001);
    tend("checksum");
    run_op(OP_RAW, 8'h82, 16'h0800);
    rd(8'h83, 16'h0000, "pump refused");
    run_op(OP_ARM, 8'h00, 16'h0000);
    rd(8'h97, 16'h0800, "write enable");
    rd(8'h83, 16'h0800, "pump clock");
    chk("pump on", {15'h0, pump_on}, 16'h0001);
    run_op(OP_RAW, 8'h12, 16'h1234);
    repeat (2) @(negedge sys_clk);
    chk("nvm word", mem[9], 16'h1234);
    run_op(OP_CRC, 8'h00, 16'h0000);
    chk("new crc", {8'h00, m_crc}, {8'h00, crc8()});
    chk("new match", {15'h0, m_match}, {15'h0, crc8() == mem[15][7:0]});
    tend("programming");
    corr_err = 1'b1;
    dbl_err = 1'b1;
    rd(8'h11, 16'h0000, "nvm read");
    corr_err = 1'b0;
    dbl_err = 1'b0;
    rd(8'h83, 16'h8980, "ecc flags");
    pins = 4'hF;
    repeat (4) @(negedge sys_clk);
    rd(8'h83, 16'h99E0, "pin flags");
    run_op(OP_RAW, 8'h82, 16'h4800);
    chk("diag off", {15'h0, diag_mode}, 16'h0000);
    pins = 4'h0;
    repeat (4) @(negedge sys_clk);
    rd(8'h83, 16'h99E0, "sticky flags");
    tend("diagnostics");
    // restore the programmed word so the start-up sum is clean again
    mem[9] = WORDS[1];
    do_reset();
    repeat (100) @(negedge sys_clk);
    run_op(OP_ENTER, 8'h00, 16'h0000);
    chk("late entry", {15'h0, cmd_mode}, 16'h0000);
    pins = 4'h4;
    repeat (4) @(negedge sys_clk);
    chk("loss masked", {15'h0, diag_mode}, 16'h0000);
    pins = 4'h5;
    @(negedge sys_clk);
    chk("loss diag", {15'h0, diag_mode}, 16'h0001);
    run_op(OP_ENTER, 8'h00, 16'h0000);
    chk("diag entry", {15'h0, cmd_mode}, 16'h0001);
    rd(8'h83, 16'h8040, "loss status");
    tend("late entry");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
